// ### hw/thca_top.sv
// Toggle handshake command acceptor on the cyclic process data channel
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module thca_top
   import thca_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic cycle_strobe,
   input wire logic [PD_BYTES*8-1:0] rx_data,
   input wire logic exec_done,
   input wire logic exec_reject,
   input wire logic param_valid,
   input wire logic param_read,
   input wire logic param_write,
   output logic [PD_BYTES*8-1:0] cmd_data,
   output logic cmd_start,
   output logic [7:0] mode_status_field,
   output logic busy,
   output logic param_accept,
   output logic param_error,
   output thca_pacc_t param_kind
);
   // ==========================================================
   // Field extraction
   function automatic logic [7:0] pd_byte(
      input logic [PD_BYTES*8-1:0] d, input int idx);
      pd_byte = d[idx*8 +: 8];
   endfunction

   // Toggle and mode sit in the mode control byte of a data image
   function automatic logic ctrl_toggle(
      input logic [PD_BYTES*8-1:0] d);
      ctrl_toggle = d[MODE_CTRL_BYTE*8 + TOGGLE_BIT];
   endfunction

   function automatic logic [MODE_FIELD_W-1:0] ctrl_mode(
      input logic [PD_BYTES*8-1:0] d);
      ctrl_mode = d[MODE_CTRL_BYTE*8 + MODE_FIELD_LSB +: MODE_FIELD_W];
   endfunction

   logic [7:0] mode_control_field;
   logic mode_toggle_flag;
   logic status_toggle;
   logic mode_reject_flag;
   logic new_cmd;
   logic verdict;
   thca_state_t state;

   assign mode_control_field = pd_byte(rx_data, MODE_CTRL_BYTE);
   assign mode_toggle_flag = mode_control_field[TOGGLE_BIT];
   assign status_toggle = mode_status_field[TOGGLE_BIT];
   assign mode_reject_flag = mode_status_field[REJECT_BIT];
   // Only sampled on the bus cycle strobe; data between cycles is unstable
   assign new_cmd = cycle_strobe && (mode_toggle_flag != status_toggle)
      && state == thca_idle;
   assign busy = state == thca_wait_exec;
   // Verdict only counts while a command is outstanding
   assign verdict = busy && (exec_done || exec_reject);

   // ==========================================================
   // Command latch, only on an accepted toggle
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cmd_data <= {PD_BYTES{CMD_BYTE_RST}};
      end else if (new_cmd) begin
         cmd_data <= rx_data;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cmd_start <= 1'b0;
      end else begin
         cmd_start <= new_cmd;
      end
   end

   // ==========================================================
   // Execution sequencer
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state <= thca_idle;
      end else begin
         case (state)
            thca_idle: begin
               if (new_cmd) begin
                  state <= thca_wait_exec;
               end
            end
            thca_wait_exec: begin
               if (exec_done || exec_reject) begin
                  state <= thca_idle;
               end
            end
            default: state <= thca_idle;
         endcase
      end
   end

   // ==========================================================
   // Status field: toggle mirror and reject flag
   // Mirror waits for the verdict so reject and toggle appear together
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mode_status_field <= MODE_STATUS_RST;
      end else begin
         if (verdict) begin
            mode_status_field[TOGGLE_BIT] <= ctrl_toggle(cmd_data);
            mode_status_field[REJECT_BIT] <= exec_reject;
            mode_status_field[MODE_FIELD_LSB +: MODE_FIELD_W] <=
               ctrl_mode(cmd_data);
         end
      end
   end

   thca_param_gate i_thca_param_gate (
      .mclk(mclk),
      .rstn(rstn),
      .param_valid(param_valid),
      .param_read(param_read),
      .param_write(param_write),
      .param_accept(param_accept),
      .param_error(param_error),
      .param_kind(param_kind)
   );

   // ==========================================================
   // Checks
   a_ignore_equal: assert property (
      @(posedge mclk) disable iff (!rstn)
      cycle_strobe && mode_toggle_flag == status_toggle |=> !cmd_start)
      else $error("command started with equal toggles");
   a_start_on_change: assert property (
      @(posedge mclk) disable iff (!rstn)
      cycle_strobe && state == thca_idle
      && mode_toggle_flag != status_toggle
      |=> cmd_start && cmd_data == $past(rx_data))
      else $error("toggle change not accepted");
   a_only_strobe: assert property (
      @(posedge mclk) disable iff (!rstn)
      !cycle_strobe |=> !cmd_start)
      else $error("start outside bus cycle");
   a_mirror_toggle: assert property (
      @(posedge mclk) disable iff (!rstn)
      busy && exec_done
      |=> mode_status_field[TOGGLE_BIT] == ctrl_toggle(cmd_data))
      else $error("toggle not mirrored");
   a_reject_flag: assert property (
      @(posedge mclk) disable iff (!rstn)
      busy && exec_reject |=> mode_reject_flag)
      else $error("reject not flagged");
   a_reject_hold: assert property (
      @(posedge mclk) disable iff (!rstn)
      mode_reject_flag && $stable(status_toggle) ##1 $stable(status_toggle)
      |-> mode_reject_flag)
      else $error("reject dropped without toggle");
   a_start_busy: assert property (
      @(posedge mclk) disable iff (!rstn)
      cmd_start |-> busy)
      else $error("start without busy");
   a_data_stable: assert property (
      @(posedge mclk) disable iff (!rstn)
      busy && !cmd_start |-> $stable(cmd_data))
      else $error("command data changed while busy");
   // A strobe during execution is dropped, not queued
   a_busy_refuse: assert property (
      @(posedge mclk) disable iff (!rstn)
      cycle_strobe && busy |=> !cmd_start)
      else $error("command taken while busy");
   a_start_once: assert property (
      @(posedge mclk) disable iff (!rstn)
      cmd_start |=> !cmd_start)
      else $error("start longer than one cycle");
   a_toggle_differs: assert property (
      @(posedge mclk) disable iff (!rstn)
      cmd_start |-> ctrl_toggle(cmd_data) != status_toggle)
      else $error("accepted command without toggle change");
   a_verdict_idle: assert property (
      @(posedge mclk) disable iff (!rstn)
      verdict |=> !busy)
      else $error("still busy after verdict");
   a_mode_copy: assert property (
      @(posedge mclk) disable iff (!rstn)
      verdict |=> mode_status_field[MODE_FIELD_LSB +: MODE_FIELD_W]
      == ctrl_mode(cmd_data))
      else $error("mode not reported");
   a_reject_clear: assert property (
      @(posedge mclk) disable iff (!rstn)
      verdict && !exec_reject |=> !mode_reject_flag)
      else $error("reject kept after good verdict");
   a_reject_toggles: assert property (
      @(posedge mclk) disable iff (!rstn)
      $fell(mode_reject_flag) |-> $changed(status_toggle))
      else $error("reject cleared without toggle");
   // Status moves only on a verdict, never on raw bus traffic
   a_status_quiet: assert property (
      @(posedge mclk) disable iff (!rstn)
      !verdict |=> $stable(mode_status_field))
      else $error("status changed without verdict");

   c_accept: cover property (@(posedge mclk) disable iff (!rstn)
      cmd_start ##[1:20] !busy);
   c_reject: cover property (@(posedge mclk) disable iff (!rstn)
      busy && exec_reject);
   c_ignored: cover property (@(posedge mclk) disable iff (!rstn)
      cycle_strobe && mode_toggle_flag == status_toggle);
   c_busy_refused: cover property (@(posedge mclk) disable iff (!rstn)
      cycle_strobe && busy);
   c_reject_cleared: cover property (@(posedge mclk) disable iff (!rstn)
      $fell(mode_reject_flag));
endmodule
`default_nettype wire

// ### hw/thca_pkg.sv
// Package for the toggle handshake command acceptor
package thca_pkg;
   // ==========================================================
   // Process data layout
   localparam int PD_BYTES = 12;
   localparam int MODE_CTRL_BYTE = 9;
   localparam int TOGGLE_BIT = 7;
   localparam int REJECT_BIT = 6;
   localparam int MODE_FIELD_LSB = 0;
   localparam int MODE_FIELD_W = 3;
   // ==========================================================
   // Reset values
   localparam logic [7:0] MODE_STATUS_RST = 8'h00;
   localparam logic [7:0] CMD_BYTE_RST = 8'h00;
   // ==========================================================
   // Parameter channel access kinds
   typedef enum logic [1:0] {
      thca_pacc_none,
      thca_pacc_read,
      thca_pacc_write
   } thca_pacc_t;
   // Acceptance sequencer states
   typedef enum {
      thca_idle,
      thca_wait_exec
   } thca_state_t;
endpackage

// ### hw/thca_param_gate.sv
// Single-object gate for parameter channel transactions
`timescale 1ns/1ps
`default_nettype none
module thca_param_gate
   import thca_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic param_valid,
   input wire logic param_read,
   input wire logic param_write,
   output logic param_accept,
   output logic param_error,
   output thca_pacc_t param_kind
);
   // ==========================================================
   // One access per transaction
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         param_accept <= 1'b0;
         param_error <= 1'b0;
         param_kind <= thca_pacc_none;
      end else begin
         param_accept <= param_valid && (param_read ^ param_write);
         param_error <= param_valid && !(param_read ^ param_write);
         if (param_valid && param_read && !param_write) begin
            param_kind <= thca_pacc_read;
         end else if (param_valid && param_write && !param_read) begin
            param_kind <= thca_pacc_write;
         end else begin
            param_kind <= thca_pacc_none;
         end
      end
   end

   a_param_single: assert property (
      @(posedge mclk) disable iff (!rstn)
      param_valid && param_read && param_write
      |=> !param_accept && param_error)
      else $error("double access accepted");
endmodule
`default_nettype wire

// ### test/thca_master.sv
// Fieldbus master model that fills process data and strobes bus cycles
`timescale 1ns/1ps
`default_nettype none
module thca_master
   import thca_pkg::*;
(
   input wire logic mclk,
   output logic cycle_strobe,
   output logic [PD_BYTES*8-1:0] rx_data
);
   initial begin
      cycle_strobe = 1'b0;
      rx_data = '0;
   end
   // ==========================================================
   // Writes done before the strobe, so no bus cycle sees a half copy
   task automatic post(input logic [7:0] seed, input logic [2:0] mode,
         input logic flip);
      for (int k = PD_BYTES - 1; k >= 0; k--) begin
         @(posedge mclk);
         if (k == MODE_CTRL_BYTE)
            rx_data[8*k +: 7] <= {seed[3:0], mode};
         else
            rx_data[8*k +: 8] <= seed ^ k[7:0];
      end
      @(posedge mclk);
      rx_data[MODE_CTRL_BYTE*8 + TOGGLE_BIT] <=
         rx_data[MODE_CTRL_BYTE*8 + TOGGLE_BIT] ^ flip;
      @(posedge mclk);
      cycle_strobe <= 1'b1;
      @(posedge mclk);
      cycle_strobe <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### test/toggle_handshake_command_accept_bench.sv
// Self-checking bench for the toggle handshake command acceptor
`timescale 1ns/1ps
`default_nettype none
module toggle_handshake_command_accept_bench
   import thca_pkg::*;
();
   logic mclk = 1'b0;
   logic rstn, exec_done, exec_reject, cycle_strobe, cmd_start, busy;
   logic param_valid, param_read, param_write, param_accept, param_error;
   logic [PD_BYTES*8-1:0] rx_data, cmd_data;
   logic [7:0] mode_status_field;
   thca_pacc_t param_kind;
   logic tog = 1'b0;
   int n_mismatch = 0;
   int compares = 0;
   always #4 mclk = ~mclk;
   thca_master i_thca_master(.mclk(mclk), .cycle_strobe(cycle_strobe),
      .rx_data(rx_data));
   thca_top i_thca_top(.mclk(mclk), .rstn(rstn),
      .cycle_strobe(cycle_strobe), .rx_data(rx_data),
      .exec_done(exec_done), .exec_reject(exec_reject),
      .param_valid(param_valid), .param_read(param_read),
      .param_write(param_write), .cmd_data(cmd_data),
      .cmd_start(cmd_start), .mode_status_field(mode_status_field),
      .busy(busy), .param_accept(param_accept),
      .param_error(param_error), .param_kind(param_kind));
   // ==========================================================
   task automatic chk(input string what, input logic [95:0] exp, got);
      compares++;
      if (exp !== got) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask
   task automatic wrap_up();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Toggled command, then an ok or reject verdict
   task automatic t_cmd(input logic [7:0] seed, input logic [2:0] mode,
         input logic rej);
      logic [95:0] sent;
      i_thca_master.post(seed, mode, 1'b1);
      tog = ~tog;
      sent = rx_data;
      #1;
      chk("cmd_start", 1, cmd_start);
      chk("cmd_data", sent, cmd_data);
      chk("busy", 1, busy);
      @(posedge mclk);
      exec_done <= ~rej;
      exec_reject <= rej;
      @(posedge mclk);
      exec_done <= 1'b0;
      exec_reject <= 1'b0;
      #1;
      chk("status", {tog, rej, 3'h0, mode}, mode_status_field);
      chk("idle", 0, busy);
   endtask
   // Equal toggle must start no command and leave cmd_data untouched
   task automatic t_same();
      logic [95:0] held;
      held = cmd_data;
      i_thca_master.post(8'h5a, 3'h2, 1'b0);
      #1;
      chk("no start", 0, cmd_start);
      @(posedge mclk);
      #1;
      chk("held data", held, cmd_data);
   endtask
   // Strobe while a command waits for its verdict is refused
   task automatic t_busy();
      logic [95:0] sent;
      i_thca_master.post(8'h6c, 3'h3, 1'b1);
      tog = ~tog;
      sent = rx_data;
      i_thca_master.post(8'h77, 3'h4, 1'b0);
      #1;
      chk("busy start", 0, cmd_start);
      chk("busy data", sent, cmd_data);
      chk("still busy", 1, busy);
      @(posedge mclk);
      exec_done <= 1'b1;
      @(posedge mclk);
      exec_done <= 1'b0;
      #1;
      chk("busy status", {tog, 1'b0, 3'h0, 3'h3}, mode_status_field);
   endtask
   task automatic t_param(input logic rd, wr, input logic [1:0] kind,
         input logic err);
      @(posedge mclk);
      param_valid <= 1'b1;
      param_read <= rd;
      param_write <= wr;
      @(posedge mclk);
      param_valid <= 1'b0;
      #1;
      chk("accept", !err, param_accept);
      chk("error", err, param_error);
      chk("kind", kind, param_kind);
   endtask
   // ==========================================================
   initial begin
      repeat (5000) @(posedge mclk);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      {rstn, exec_done, exec_reject} = 3'h0;
      {param_valid, param_read, param_write} = 3'h0;
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      #1;
      chk("reset status", MODE_STATUS_RST, mode_status_field);
      t_cmd(8'h11, 3'h1, 1'b0);
      t_cmd(8'h22, 3'h5, 1'b1);
      t_cmd(8'h33, 3'h7, 1'b0);
      t_same();
      t_busy();
      t_param(1'b1, 1'b0, 2'h1, 1'b0);
      t_param(1'b0, 1'b1, 2'h2, 1'b0);
      t_param(1'b1, 1'b1, 2'h0, 1'b1);
      t_param(1'b0, 1'b0, 2'h0, 1'b1);
      wrap_up();
   end
endmodule
`default_nettype wire
